//--- t1_framer_control_map.vh
`ifndef T1_FRAMER_CONTROL_MAP_VH
`define T1_FRAMER_CONTROL_MAP_VH
// ----------------------------------------
// Register indices, byte address is 4x
// ----------------------------------------
`define IDX_MASTER_MODE 6'h00
`define IDX_IO_CONFIG 6'h02
`define IDX_RX_SYNC 6'h03
`define IDX_RX_FORMAT 6'h04
`define IDX_TX_FORMAT 6'h05
`define IDX_TX_CODING 6'h06
`define IDX_COMMON_LINE 6'h07
`define IDX_SIG_EN_LO 6'h08
`define IDX_SIG_EN_MID 6'h09
`define IDX_SIG_EN_HI 6'h0a
`define IDX_INFO_ONE 6'h10
`define REG_RESET 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_E1_MODE 1
`define B_TX_SYSCLK 1
`define B_RX_SYSCLK 0
`define B_CRIT_OOF 6
`define B_OOF_HI 5
`define B_OOF_LO 4
`define B_CRIT_SEL 3
`define B_QUAL_LEN 2
`define B_AUTO_OFF 1
`define B_RESYNC 0
`define B_RX_ESF 6
`define B_RX_ZSUB 5
`define B_RX_JCRC 1
`define B_RYEL 0
`define B_TX_JCRC 7
`define B_F_PASS 6
`define B_CRC_PASS 5
`define B_SW_SIG 4
`define B_STUFF_ALL 3
`define B_LINK_SRC 2
`define B_BLUE 1
`define B_TX_YEL 0
`define B_TX_ZSUB 7
`define B_F_PERIOD 4
`define B_F_BURST 3
`define B_TYELS 2
`define B_ZSUPP 0
`define B_RAI_CI 4
`define B_AIS_CI 3
`define B_TX_ESF 2
`define B_ENFORCE 1
`define B_RX_DENS 7
`define B_TX_DENS 6
`define B_OOF_ST 1
`define B_SYNC_ST 0
// ----------------------------------------
// Counts
// ----------------------------------------
`define QUAL_SHORT 5'd10
`define QUAL_LONG 5'd24
`define BURST_LEN 2'd3
`define ZERO_RUN_MAX 4'd15
`define CH_BIT7 1
`define CH_BIT2 6
`define SLOT_FT 2'd0
`define SLOT_CRC 2'd1
`define SLOT_FDL 2'd2
`endif

//--- t1_framer_control.v
`timescale 1ns/100ps
`include "t1_framer_control_map.vh"
module t1_framer_control #(
  parameter N_MAX = 23,
  parameter CORRUPT_PERIOD = 128
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Receive framing events
  input wire rx_fbit_stb,
  input wire rx_fbit_ok,
  input wire rx_crc_stb,
  input wire rx_crc_ok,
  input wire rx_carrier_loss,
  output reg rx_in_sync,
  output reg rx_oof,
  output reg rx_search_fs,
  output reg rx_slip,
  // Mode outputs
  output reg e1_mode,
  output reg rx_esf,
  output reg tx_esf,
  output reg rx_b8zs,
  output reg tx_b8zs,
  output reg rx_jcrc,
  output reg tx_jcrc,
  output reg rx_yellow_s12,
  output reg tx_sysclk_2m,
  output reg rx_sysclk_2m,
  output reg tx_ais_ci_send,
  // Transmit channel bytes
  input wire tx_byte_stb,
  input wire [4:0] tx_chan,
  input wire [7:0] tx_byte,
  output reg tx_byte_out_stb,
  output reg [7:0] tx_byte_out,
  output reg tx_sig_from_regs,
  // Transmit framing bits
  input wire tx_fslot_stb,
  input wire [1:0] tx_slot_kind,
  input wire tx_frame12,
  input wire tx_fbit_internal,
  input wire tx_crc_internal,
  input wire tx_serial_in,
  input wire tx_fdl_legacy,
  input wire tx_fdl_hdlc,
  input wire tx_rai_ci_bit,
  output reg tx_fbit_out_stb,
  output reg tx_fbit_out,
  // Line bit streams
  input wire rx_line_stb,
  input wire rx_line_bit,
  input wire tx_line_stb,
  input wire tx_line_bit,
  output reg tx_line_out_stb,
  output reg tx_line_out
);

  localparam [31:0] WIN = 8 * (N_MAX + 1);
  localparam [7:0] WIN8 = WIN[7:0];
  localparam [2:0] ST_HUNT = 3'd0;
  localparam [2:0] ST_CRC = 3'd1;
  localparam [2:0] ST_SYNC = 3'd2;
  localparam [31:0] CP_FULL = CORRUPT_PERIOD - 1;
  localparam [6:0] CP_LAST = CP_FULL[6:0];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [7:0] master_mode_reg;
  reg [7:0] io_config_reg;
  reg [7:0] receive_sync_control_reg;
  reg [7:0] receive_format_control_reg;
  reg [7:0] transmit_format_control_reg;
  reg [7:0] transmit_coding_control_reg;
  reg [7:0] common_line_control_reg;
  reg [23:0] sig_insert_en_reg;
  reg rx_dens_flag_reg;
  reg tx_dens_flag_reg;
  reg [7:0] rd_next;
  wire [5:0] idx = wb_adr_i[7:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire t1_on = ~master_mode_reg[`B_E1_MODE];
  wire rx_dens_viol;
  wire tx_dens_viol;

  always @* begin
    case (idx)
      `IDX_MASTER_MODE: rd_next = master_mode_reg;
      `IDX_IO_CONFIG: rd_next = io_config_reg;
      `IDX_RX_SYNC: rd_next = receive_sync_control_reg;
      `IDX_RX_FORMAT: rd_next = receive_format_control_reg;
      `IDX_TX_FORMAT: rd_next = transmit_format_control_reg;
      `IDX_TX_CODING: rd_next = transmit_coding_control_reg;
      `IDX_COMMON_LINE: rd_next = common_line_control_reg;
      `IDX_SIG_EN_LO: rd_next = sig_insert_en_reg[7:0];
      `IDX_SIG_EN_MID: rd_next = sig_insert_en_reg[15:8];
      `IDX_SIG_EN_HI: rd_next = sig_insert_en_reg[23:16];
      `IDX_INFO_ONE: rd_next = {rx_dens_flag_reg, tx_dens_flag_reg, 4'h0,
                                rx_oof, rx_in_sync};
      default: rd_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      master_mode_reg <= `REG_RESET;
      io_config_reg <= `REG_RESET;
      receive_sync_control_reg <= `REG_RESET;
      receive_format_control_reg <= `REG_RESET;
      transmit_format_control_reg <= `REG_RESET;
      transmit_coding_control_reg <= `REG_RESET;
      common_line_control_reg <= `REG_RESET;
      sig_insert_en_reg <= 24'h000000;
      rx_dens_flag_reg <= 1'b0;
      tx_dens_flag_reg <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h000000, rd_next} : 32'h00000000;
      if (wr) begin
        case (idx)
          `IDX_MASTER_MODE: master_mode_reg <= wd & 8'h02;
          `IDX_IO_CONFIG: io_config_reg <= wd;
          `IDX_RX_SYNC: receive_sync_control_reg <= wd & 8'h7f;
          `IDX_RX_FORMAT: receive_format_control_reg <= wd & 8'h7b;
          `IDX_TX_FORMAT: transmit_format_control_reg <= wd;
          `IDX_TX_CODING: transmit_coding_control_reg <= wd & 8'hfd;
          `IDX_COMMON_LINE: common_line_control_reg <= wd & 8'h1f;
          `IDX_SIG_EN_LO: sig_insert_en_reg[7:0] <= wd;
          `IDX_SIG_EN_MID: sig_insert_en_reg[15:8] <= wd;
          `IDX_SIG_EN_HI: sig_insert_en_reg[23:16] <= wd;
          default: ;
        endcase
      end
      rx_dens_flag_reg <= rx_dens_viol | (rx_dens_flag_reg &
        ~(wr && idx == `IDX_INFO_ONE && wd[`B_RX_DENS]));
      tx_dens_flag_reg <= tx_dens_viol | (tx_dens_flag_reg &
        ~(wr && idx == `IDX_INFO_ONE && wd[`B_TX_DENS]));
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      e1_mode <= 1'b0;
      rx_esf <= 1'b0;
      tx_esf <= 1'b0;
      rx_b8zs <= 1'b0;
      tx_b8zs <= 1'b0;
      rx_jcrc <= 1'b0;
      tx_jcrc <= 1'b0;
      rx_yellow_s12 <= 1'b0;
      tx_sysclk_2m <= 1'b0;
      rx_sysclk_2m <= 1'b0;
      tx_ais_ci_send <= 1'b0;
    end else if (ce) begin
      e1_mode <= master_mode_reg[`B_E1_MODE];
      rx_esf <= receive_format_control_reg[`B_RX_ESF];
      tx_esf <= common_line_control_reg[`B_TX_ESF];
      rx_b8zs <= receive_format_control_reg[`B_RX_ZSUB];
      tx_b8zs <= transmit_coding_control_reg[`B_TX_ZSUB];
      rx_jcrc <= receive_format_control_reg[`B_RX_JCRC];
      tx_jcrc <= transmit_format_control_reg[`B_TX_JCRC];
      rx_yellow_s12 <= receive_format_control_reg[`B_RYEL];
      tx_sysclk_2m <= io_config_reg[`B_TX_SYSCLK];
      rx_sysclk_2m <= io_config_reg[`B_RX_SYSCLK];
      tx_ais_ci_send <= t1_on & common_line_control_reg[`B_AIS_CI] &
                        transmit_format_control_reg[`B_BLUE];
    end
  end

  // ----------------------------------------
  // Receive sync control
  // ----------------------------------------
  reg [2:0] sync_state_reg;
  reg [4:0] qual_cnt_reg;
  reg [5:0] err_hist_reg;
  reg resync_prev_reg;
  wire auto_resync_criterion = receive_sync_control_reg[`B_CRIT_OOF];
  wire [1:0] oof_sel = {receive_sync_control_reg[`B_OOF_HI],
                        receive_sync_control_reg[`B_OOF_LO]};
  wire sync_crit = receive_sync_control_reg[`B_CRIT_SEL];
  wire [4:0] qual_target = receive_sync_control_reg[`B_QUAL_LEN] ?
                           `QUAL_LONG : `QUAL_SHORT;
  wire auto_on = ~receive_sync_control_reg[`B_AUTO_OFF];
  wire resync_bit = receive_sync_control_reg[`B_RESYNC];
  wire [5:0] err_win = {err_hist_reg[4:0], ~rx_fbit_ok};
  reg [5:0] win_mask;
  wire [2:0] err_cnt;
  wire oof_now;
  wire resync_cmd;
  wire auto_trig;

  always @* begin
    case (oof_sel)
      2'b00: win_mask = 6'h0f;
      2'b01: win_mask = 6'h1f;
      default: win_mask = 6'h3f;
    endcase
  end

  function [2:0] ones6;
    input [5:0] v;
    begin
      ones6 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} +
              {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
    end
  endfunction

  assign err_cnt = ones6(err_win & win_mask);
  assign oof_now = rx_fbit_stb & (err_cnt >= 3'd2);
  assign resync_cmd = resync_bit & ~resync_prev_reg;
  assign auto_trig = auto_on & (oof_now | (rx_carrier_loss & ~auto_resync_criterion));

  always @(posedge clk_sys) begin
    if (srst) begin
      sync_state_reg <= ST_HUNT;
      qual_cnt_reg <= 5'd0;
      err_hist_reg <= 6'h00;
      resync_prev_reg <= 1'b0;
      rx_in_sync <= 1'b0;
      rx_oof <= 1'b1;
      rx_search_fs <= 1'b0;
      rx_slip <= 1'b0;
    end else if (ce) begin
      resync_prev_reg <= resync_bit;
      rx_slip <= 1'b0;
      if (!t1_on) begin
        sync_state_reg <= ST_HUNT;
        qual_cnt_reg <= 5'd0;
        rx_in_sync <= 1'b0;
        rx_oof <= 1'b1;
        rx_search_fs <= 1'b0;
      end else if (resync_cmd || (sync_state_reg == ST_SYNC && auto_trig)) begin
        sync_state_reg <= ST_HUNT;
        qual_cnt_reg <= 5'd0;
        err_hist_reg <= 6'h00;
        rx_in_sync <= 1'b0;
        rx_oof <= 1'b1;
        rx_search_fs <= 1'b0;
      end else begin
        case (sync_state_reg)
          ST_HUNT: begin
            if (rx_fbit_stb && !rx_fbit_ok) begin
              qual_cnt_reg <= 5'd0;
              rx_slip <= 1'b1;
            end else if (rx_fbit_stb && qual_cnt_reg + 5'd1 < qual_target) begin
              qual_cnt_reg <= qual_cnt_reg + 5'd1;
            end else if (rx_fbit_stb) begin
              qual_cnt_reg <= 5'd0;
              if (!rx_esf && !sync_crit && !rx_search_fs) begin
                rx_search_fs <= 1'b1;
              end else if (rx_esf && sync_crit) begin
                sync_state_reg <= ST_CRC;
              end else begin
                sync_state_reg <= ST_SYNC;
                rx_in_sync <= 1'b1;
                rx_oof <= 1'b0;
                rx_search_fs <= 1'b0;
              end
            end
          end
          ST_CRC: begin
            if (rx_crc_stb && rx_crc_ok) begin
              sync_state_reg <= ST_SYNC;
              rx_in_sync <= 1'b1;
              rx_oof <= 1'b0;
            end else if (rx_crc_stb) begin
              sync_state_reg <= ST_HUNT;
              rx_slip <= 1'b1;
            end
          end
          ST_SYNC: begin
            if (rx_fbit_stb) begin
              err_hist_reg <= err_win;
            end
            if (oof_now) begin
              rx_oof <= 1'b1;
              rx_in_sync <= 1'b0;
              err_hist_reg <= 6'h00;
            end
          end
          default: sync_state_reg <= ST_HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Transmit channel bytes
  // ----------------------------------------
  reg [7:0] byte_next;
  wire ch_en = sig_insert_en_reg[tx_chan];
  wire blue = transmit_format_control_reg[`B_BLUE];
  wire tx_yel = transmit_format_control_reg[`B_TX_YEL];
  wire tx_yel_s12 = transmit_coding_control_reg[`B_TYELS];

  always @* begin
    byte_next = tx_byte;
    if (tx_byte == 8'h00 && transmit_coding_control_reg[`B_ZSUPP] &&
        (transmit_format_control_reg[`B_STUFF_ALL] || ch_en)) begin
      byte_next[`CH_BIT7] = 1'b1;
    end
    if (tx_yel && !tx_esf && !tx_yel_s12) begin
      byte_next[`CH_BIT2] = 1'b0;
    end
    if (blue) begin
      byte_next = 8'hff;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      tx_byte_out_stb <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_sig_from_regs <= 1'b0;
    end else if (ce) begin
      tx_byte_out_stb <= tx_byte_stb & t1_on;
      if (tx_byte_stb && t1_on) begin
        tx_byte_out <= byte_next;
        tx_sig_from_regs <= transmit_format_control_reg[`B_SW_SIG] & ch_en & ~blue;
      end
    end
  end

  // ----------------------------------------
  // Transmit framing bits
  // ----------------------------------------
  reg [6:0] ft_cnt_reg;
  reg [1:0] burst_cnt_reg;
  reg burst_prev_reg;
  reg fbit_next;
  wire burst_bit = transmit_coding_control_reg[`B_F_BURST];
  wire ft_slot = tx_fslot_stb & t1_on & (tx_slot_kind == `SLOT_FT);
  wire corrupt = (transmit_coding_control_reg[`B_F_PERIOD] && ft_cnt_reg == CP_LAST) ||
                 (burst_cnt_reg != 2'd0);

  always @* begin
    fbit_next = tx_fbit_internal;
    case (tx_slot_kind)
      `SLOT_FT: begin
        if (transmit_format_control_reg[`B_F_PASS]) begin
          fbit_next = tx_serial_in;
        end
        if (corrupt) begin
          fbit_next = ~fbit_next;
        end
      end
      `SLOT_CRC: begin
        fbit_next = (transmit_format_control_reg[`B_CRC_PASS] ||
                     transmit_format_control_reg[`B_F_PASS]) ?
                    tx_serial_in : tx_crc_internal;
      end
      `SLOT_FDL: begin
        fbit_next = transmit_format_control_reg[`B_LINK_SRC] ?
                    tx_fdl_hdlc : tx_fdl_legacy;
        if (common_line_control_reg[`B_RAI_CI] && tx_esf) begin
          fbit_next = tx_rai_ci_bit;
        end
        if (tx_yel && !tx_esf && tx_yel_s12 && tx_frame12) begin
          fbit_next = 1'b1;
        end
        if (transmit_format_control_reg[`B_F_PASS]) begin
          fbit_next = tx_serial_in;
        end
      end
      default: fbit_next = tx_fbit_internal;
    endcase
    if (blue) begin
      fbit_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      ft_cnt_reg <= 7'd0;
      burst_cnt_reg <= 2'd0;
      burst_prev_reg <= 1'b0;
      tx_fbit_out_stb <= 1'b0;
      tx_fbit_out <= 1'b0;
    end else if (ce) begin
      burst_prev_reg <= burst_bit;
      tx_fbit_out_stb <= tx_fslot_stb & t1_on;
      if (tx_fslot_stb && t1_on) begin
        tx_fbit_out <= fbit_next;
      end
      if (!transmit_coding_control_reg[`B_F_PERIOD]) begin
        ft_cnt_reg <= 7'd0;
      end else if (ft_slot) begin
        ft_cnt_reg <= (ft_cnt_reg == CP_LAST) ? 7'd0 : ft_cnt_reg + 7'd1;
      end
      if (burst_bit && !burst_prev_reg) begin
        burst_cnt_reg <= `BURST_LEN;
      end else if (ft_slot && burst_cnt_reg != 2'd0) begin
        burst_cnt_reg <= burst_cnt_reg - 2'd1;
      end
    end
  end

  // ----------------------------------------
  // Pulse density monitors and enforcer
  // ----------------------------------------
  reg [WIN-1:0] rx_hist_reg;
  reg [WIN-1:0] tx_hist_reg;
  reg [7:0] rx_fill_reg;
  reg [7:0] tx_fill_reg;
  reg [3:0] rx_zrun_reg;
  reg [3:0] tx_zrun_reg;
  wire [N_MAX:1] rx_win_bad;
  wire [N_MAX:1] tx_bad0;
  wire [N_MAX:1] tx_win_bad;
  wire rx_bit = rx_line_stb & t1_on;
  wire tx_bit = tx_line_stb & t1_on;
  wire tx_would0 = (tx_zrun_reg == `ZERO_RUN_MAX) | (|tx_bad0);
  wire tx_eff = tx_line_bit |
                (common_line_control_reg[`B_ENFORCE] & tx_would0);

  genvar n;
  generate
    for (n = 1; n <= N_MAX; n = n + 1) begin : g_dens
      localparam [31:0] L = 8 * (n + 1);
      localparam [31:0] NW = n;
      localparam [31:0] LW = L - 1;
      localparam [7:0] NN = NW[7:0];
      localparam [7:0] LM1 = LW[7:0];
      reg [7:0] rx_cnt_reg;
      reg [7:0] tx_cnt_reg;
      wire [7:0] rx_new = rx_cnt_reg - {7'd0, rx_hist_reg[L-1]} +
                          {7'd0, rx_line_bit};
      wire [7:0] tx_new0 = tx_cnt_reg - {7'd0, tx_hist_reg[L-1]};
      wire [7:0] tx_new = tx_new0 + {7'd0, tx_eff};
      assign rx_win_bad[n] = (rx_fill_reg >= LM1) && (rx_new < NN);
      assign tx_bad0[n] = (tx_fill_reg >= LM1) && (tx_new0 < NN);
      assign tx_win_bad[n] = (tx_fill_reg >= LM1) && (tx_new < NN);
      always @(posedge clk_sys) begin
        if (srst) begin
          rx_cnt_reg <= 8'd0;
          tx_cnt_reg <= 8'd0;
        end else if (ce) begin
          if (rx_bit) begin
            rx_cnt_reg <= rx_new;
          end
          if (tx_bit) begin
            tx_cnt_reg <= tx_new;
          end
        end
      end
    end
  endgenerate

  assign rx_dens_viol = rx_bit &
    (((rx_zrun_reg == `ZERO_RUN_MAX) & ~rx_line_bit) | (|rx_win_bad));
  assign tx_dens_viol = tx_bit &
    ((tx_would0 & ~tx_line_bit) | (|tx_win_bad));

  always @(posedge clk_sys) begin
    if (srst) begin
      rx_hist_reg <= {WIN{1'b0}};
      tx_hist_reg <= {WIN{1'b0}};
      rx_fill_reg <= 8'd0;
      tx_fill_reg <= 8'd0;
      rx_zrun_reg <= 4'd0;
      tx_zrun_reg <= 4'd0;
      tx_line_out_stb <= 1'b0;
      tx_line_out <= 1'b0;
    end else if (ce) begin
      tx_line_out_stb <= tx_bit;
      if (rx_bit) begin
        rx_hist_reg <= {rx_hist_reg[WIN-2:0], rx_line_bit};
        rx_fill_reg <= (rx_fill_reg == WIN8) ? WIN8 : rx_fill_reg + 8'd1;
        rx_zrun_reg <= rx_line_bit ? 4'd0 :
          ((rx_zrun_reg == `ZERO_RUN_MAX) ? rx_zrun_reg : rx_zrun_reg + 4'd1);
      end
      if (tx_bit) begin
        tx_line_out <= tx_eff;
        tx_hist_reg <= {tx_hist_reg[WIN-2:0], tx_eff};
        tx_fill_reg <= (tx_fill_reg == WIN8) ? WIN8 : tx_fill_reg + 8'd1;
        tx_zrun_reg <= tx_eff ? 4'd0 :
          ((tx_zrun_reg == `ZERO_RUN_MAX) ? tx_zrun_reg : tx_zrun_reg + 4'd1);
      end
    end
  end

endmodule

//--- t1_framer_control_assertions.sv
`timescale 1ns/100ps
// ----
// Bus and strobe checks
// ----
module t1_framer_control_assertions (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  input wire ce,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  // Modes and strobes
  input wire e1_mode,
  input wire rx_in_sync,
  input wire rx_oof,
  input wire tx_ais_ci_send,
  input wire tx_byte_stb,
  input wire tx_byte_out_stb,
  input wire tx_fslot_stb,
  input wire tx_fbit_out_stb
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("request not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_byte_latency: assert property (tx_byte_stb && ce && !e1_mode |=> tx_byte_out_stb)
    else $error("byte strobe lost");
  a_fbit_latency: assert property (tx_fslot_stb && ce && !e1_mode |=> tx_fbit_out_stb)
    else $error("framing strobe lost");
  a_e1_quiet: assert property (e1_mode |-> !tx_byte_out_stb && !tx_fbit_out_stb)
    else $error("strobe in E1 mode");
  a_ais_t1_only: assert property (tx_ais_ci_send |-> !e1_mode)
    else $error("AIS-CI in E1 mode");
  a_sync_oof_excl: assert property (rx_in_sync |-> !rx_oof)
    else $error("sync and out of frame together");
endmodule
bind t1_framer_control t1_framer_control_assertions chk (.*);

//--- t1_line_partner.sv
`timescale 1ns/100ps
// ----
// Far-end line: framing bit events
// ----
module t1_line_partner (
  // Control
  input wire clk_sys,
  input wire send,
  input wire err,
  // Events
  output logic rx_fbit_stb = 1'b0,
  output logic rx_fbit_ok = 1'b0,
  output logic rx_crc_stb = 1'b0,
  output logic rx_crc_ok = 1'b0
);
  logic ph = 1'b0;
  always @(posedge clk_sys) begin
    ph <= ~ph;
    rx_fbit_stb <= send & ph;
    // Qualifier toggles between events so a stale value is never valid
    rx_fbit_ok <= (send & ph) ? ~err : ~rx_fbit_ok;
    rx_crc_stb <= send & ph;
    rx_crc_ok <= (send & ph) ? ~err : ~rx_crc_ok;
  end
endmodule

//--- tb_t1_framer_control.sv
`timescale 1ns/100ps
module tb_t1_framer_control;
  logic clk_sys = 0, srst = 1, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0, tx_byte = 0, tx_byte_out, rd;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic [4:0] tx_chan = 0;
  logic [1:0] tx_slot_kind = 0;
  logic rx_fbit_stb, rx_fbit_ok, rx_crc_stb, rx_crc_ok, rx_carrier_loss = 0, rx_in_sync;
  logic rx_oof, rx_search_fs, rx_slip, e1_mode, rx_esf, tx_esf, rx_b8zs, tx_b8zs, rx_jcrc;
  logic tx_jcrc, rx_yellow_s12, tx_sysclk_2m, rx_sysclk_2m, tx_ais_ci_send, tx_sig_from_regs;
  logic tx_byte_stb = 0, tx_byte_out_stb, tx_fslot_stb = 0, tx_frame12 = 0, tx_serial_in = 0;
  logic tx_fbit_internal = 0, tx_crc_internal = 0, tx_fdl_legacy = 0, tx_fdl_hdlc = 0;
  logic tx_rai_ci_bit = 0, tx_fbit_out_stb, tx_fbit_out, rx_line_stb = 0, rx_line_bit = 0;
  logic tx_line_stb = 0, tx_line_bit = 0, tx_line_out_stb, tx_line_out, send = 0, err = 0;
  integer bad_count = 0, n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  t1_framer_control dut (.*);
  t1_line_partner far (.*);
  // ----
  // Shared tasks
  // ----
  task wrap_up;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_compared++;
      if (g !== e) begin
        bad_count++;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    integer k;
    begin
      @(posedge clk_sys);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'b00};
      wb_dat_i <= {24'h0, d};
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (wb_ack_o !== 1'b1) begin
        bad_count++;
        wrap_up;
      end
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
    end
  endtask
  task rc(input logic [5:0] i, input logic [7:0] e);
    begin
      wb(0, i, 8'h00);
      chk(rd, e);
    end
  endtask
  task sb(input logic [7:0] b, input logic [4:0] c, input logic [7:0] e);
    begin
      @(posedge clk_sys);
      tx_byte_stb <= 1;
      tx_byte <= b;
      tx_chan <= c;
      @(posedge clk_sys);
      tx_byte_stb <= 0;
      @(posedge clk_sys);
      chk(tx_byte_out, e);
    end
  endtask
  task fs(input logic [1:0] s, input logic a, input logic b, input logic e);
    begin
      @(posedge clk_sys);
      tx_fslot_stb <= 1;
      tx_slot_kind <= s;
      {tx_fbit_internal, tx_crc_internal, tx_fdl_legacy} <= {3{a}};
      {tx_serial_in, tx_fdl_hdlc} <= {2{b}};
      @(posedge clk_sys);
      tx_fslot_stb <= 0;
      @(posedge clk_sys);
      chk(tx_fbit_out, e);
    end
  endtask
  task fb(input integer n, input logic e);
    begin
      @(posedge clk_sys);
      send <= 1;
      err <= e;
      repeat (2 * n) @(posedge clk_sys);
      send <= 0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task ln(input integer n, input logic b);
    begin
      repeat (n) begin
        @(posedge clk_sys);
        {rx_line_stb, tx_line_stb, rx_line_bit, tx_line_bit} <= {2'b11, b, b};
      end
      @(posedge clk_sys);
      {rx_line_stb, tx_line_stb} <= 2'b00;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    logic [7:0] m [5];
    begin
      m = '{8'h7f, 8'h7b, 8'hff, 8'hfd, 8'h1f};
      for (int i = 0; i < 5; i++) begin
        rc(6'(i + 3), 8'h00);
        wb(1, 6'(i + 3), 8'hff);
        rc(6'(i + 3), m[i]);
        wb(1, 6'(i + 3), 8'h00);
      end
      repeat (3) fs(2'd0, 0, 0, 1);
      wb(1, 6'h3f, 8'hff);
      rc(6'h3f, 8'h00);
    end
  endtask
  task t_modes;
    logic [5:0] ix [9];
    logic [7:0] dv [9];
    begin
      ix = '{6'h04, 6'h07, 6'h04, 6'h06, 6'h04, 6'h05, 6'h04, 6'h02, 6'h02};
      dv = '{8'h40, 8'h04, 8'h20, 8'h80, 8'h02, 8'h80, 8'h01, 8'h02, 8'h01};
      for (int i = 0; i < 9; i++) begin
        wb(1, ix[i], dv[i]);
        @(posedge clk_sys);
        chk({rx_esf, tx_esf, rx_b8zs, tx_b8zs, rx_jcrc, tx_jcrc, rx_yellow_s12,
             tx_sysclk_2m, rx_sysclk_2m}, 32'h100 >> i);
        wb(1, ix[i], 8'h00);
      end
    end
  endtask
  task t_stuff;
    begin
      wb(1, 6'h06, 8'h01);
      wb(1, 6'h05, 8'h08);
      sb(8'h00, 5'd0, 8'h02);
      sb(8'h10, 5'd3, 8'h10);
      wb(1, 6'h05, 8'h00);
      sb(8'h00, 5'd3, 8'h00);
      wb(1, 6'h08, 8'h08);
      sb(8'h00, 5'd3, 8'h02);
      chk(tx_sig_from_regs, 1'b0);
      wb(1, 6'h06, 8'h00);
      sb(8'h00, 5'd3, 8'h00);
      wb(1, 6'h08, 8'h00);
    end
  endtask
  task t_blue;
    begin
      wb(1, 6'h05, 8'h02);
      sb(8'h12, 5'd1, 8'hff);
      fs(2'd0, 0, 0, 1);
      chk(tx_ais_ci_send, 1'b0);
      wb(1, 6'h07, 8'h08);
      @(posedge clk_sys);
      chk(tx_ais_ci_send, 1'b1);
      wb(1, 6'h05, 8'h00);
      @(posedge clk_sys);
      chk(tx_ais_ci_send, 1'b0);
      wb(1, 6'h07, 8'h00);
    end
  endtask
  task t_fbits;
    begin
      wb(1, 6'h05, 8'h40);
      fs(2'd0, 0, 1, 1);
      wb(1, 6'h07, 8'h04);
      wb(1, 6'h05, 8'h20);
      fs(2'd1, 0, 1, 1);
      wb(1, 6'h05, 8'h00);
      fs(2'd2, 1, 0, 1);
      wb(1, 6'h05, 8'h04);
      fs(2'd2, 1, 0, 0);
      wb(1, 6'h05, 8'h00);
      wb(1, 6'h07, 8'h14);
      fs(2'd2, 1, 0, 0);
      wb(1, 6'h07, 8'h00);
      wb(1, 6'h06, 8'h08);
      repeat (3) fs(2'd0, 0, 0, 1);
      fs(2'd0, 0, 0, 0);
      wb(1, 6'h06, 8'h10);
      repeat (127) fs(2'd0, 0, 0, 0);
      fs(2'd0, 0, 0, 1);
      wb(1, 6'h06, 8'h00);
    end
  endtask
  task t_sync;
    begin
      fb(24, 0);
      chk(rx_in_sync, 1'b1);
      wb(1, 6'h03, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk(rx_in_sync, 1'b0);
      fb(24, 0);
      fb(3, 1);
      chk(rx_oof, 1'b1);
      fb(24, 0);
      wb(1, 6'h03, 8'h02);
      fb(3, 1);
      fb(24, 0);
      chk(rx_oof, 1'b1);
      wb(1, 6'h03, 8'h40);
      rx_carrier_loss <= 1;
      @(posedge clk_sys);
      rx_carrier_loss <= 0;
      fb(24, 0);
      chk(rx_oof, 1'b1);
      wb(1, 6'h03, 8'h00);
      rx_carrier_loss <= 1;
      @(posedge clk_sys);
      rx_carrier_loss <= 0;
      fb(24, 0);
      chk(rx_oof, 1'b0);
      wb(1, 6'h04, 8'h40);
      wb(1, 6'h03, 8'h09);
      fb(10, 0);
      chk(rx_in_sync, 1'b0);
      fb(1, 0);
      chk(rx_in_sync, 1'b1);
    end
  endtask
  task t_dens;
    begin
      ln(200, 1);
      ln(15, 0);
      ln(1, 1);
      rc(6'h10, 8'h01);
      chk(rd & 8'hc0, 8'h00);
      ln(16, 0);
      rc(6'h10, 8'hc1);
      chk(rd & 8'hc0, 8'hc0);
      chk(tx_line_out, 1'b0);
      wb(1, 6'h10, 8'hc0);
      rc(6'h10, 8'h01);
      wb(1, 6'h07, 8'h02);
      ln(1, 0);
      @(posedge clk_sys);
      chk(tx_line_out, 1'b1);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 0;
    t_regs;
    t_modes;
    t_stuff;
    t_blue;
    t_fbits;
    t_sync;
    t_dens;
    wb(1, 6'h00, 8'h02);
    @(posedge clk_sys);
    chk(e1_mode, 1'b1);
    wrap_up;
  end
endmodule
